//--- include/pwe_cfg.svh
`ifndef PWE_CFG_SVH
`define PWE_CFG_SVH
// register byte offsets
`define PWE_CTRL_OFS     8'h00
`define PWE_PEER_OFS     8'h04
`define PWE_PWLBL_OFS    8'h08
`define PWE_TUNLBL_OFS   8'h0C
`define PWE_CAP_OFS      8'h10
`define PWE_STAT_OFS     8'h14
`define PWE_DEPTH_OFS    8'h18
// field positions
`define PWE_CW_BIT       0
`define PWE_FL_BIT       1
`define PWE_SEQ_BIT      2
// reset values and capability value
`define PWE_CTRL_RST     3'h0
`define PWE_PEER_RST     2'h0
`define PWE_LBL_RST      20'h0_0000
`define PWE_DEPTH_RST    4'h0
`define PWE_SEQ_RST      16'h0001
`define PWE_CAP_VAL      2'h3
// label stack entry and control word constants
`define PWE_TUN_TTL      8'hFF
`define PWE_PW_TTL       8'hFF
`define PWE_FL_TTL       8'h00
`define PWE_EXP_VAL      3'h0
`define PWE_RSV_LBL_MAX  20'h0_000F
`define PWE_MAX_LB_LBLS  4'h3
`define PWE_CW_NIBBLE    4'h0
`define PWE_CW_RSV       12'h000
`endif

//--- include/pwe_pkg.sv
package pwe_pkg;
  typedef enum logic [2:0] {I_IDLE, I_TUN, I_PW, I_FL, I_CW, I_PAY} pwe_ing_e;
  typedef enum logic [2:0] {E_TOP, E_FL, E_CW, E_PAY, E_DROP} pwe_egr_e;
  typedef struct packed {
    // bus slave
    logic        a_valid;
    logic        a_write;
    logic [7:0]  a_addr;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    // configuration
    logic [2:0]  ctrl;
    logic [1:0]  peer;
    logic [19:0] pw_lbl;
    logic [19:0] tun_lbl;
    logic [3:0]  depth;
    // ingress
    pwe_ing_e    ist;
    logic        fl_act;
    logic        cw_act;
    logic [19:0] flow;
    logic [15:0] seq;
    logic        i_ready;
    logic        m_valid;
    logic [31:0] m_data;
    logic        m_sop;
    logic        m_eop;
    // egress
    pwe_egr_e    est;
    logic        first;
    logic [15:0] drops;
    logic        e_ready;
    logic        c_valid;
    logic [31:0] c_data;
    logic        c_sop;
    logic        c_eop;
  } pwe_state_s;
endpackage : pwe_pkg

//--- core/pwe_core.sv
`timescale 1ns/1ns
`include "pwe_cfg.svh"
// Function
// - control word first nibble is zero
// - next twelve bits reserved, sent zero
// - last sixteen bits carry sequence number
// - zero sequence means checking is off
// - insert control word, push labels above
// - egress strips control word uninterpreted
// - flow label is bottom stack entry
// - flow label S=1, TTL=0
// - flow label never in 0..15
// - flow label hashed from MAC addresses
// - same flow gives same flow label
// - egress identifies PW, strips flow label
// - no flow balancing above three labels
// - flow label generated locally only
// - advertise control word capability
// - advertise flow label capability
// - control word on by profile or peer
// - flow label on by profile or peer
module pwe_core (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // customer side frames in
  input  wire logic        i_valid,
  output logic             i_ready,
  input  wire logic [31:0] i_data,
  input  wire logic        i_sop,
  input  wire logic        i_eop,
  input  wire logic [47:0] i_dmac,
  input  wire logic [47:0] i_smac,
  // mpls side packets out
  output logic             m_valid,
  input  wire logic        m_ready,
  output logic      [31:0] m_data,
  output logic             m_sop,
  output logic             m_eop,
  // mpls side packets in
  input  wire logic        e_valid,
  output logic             e_ready,
  input  wire logic [31:0] e_data,
  input  wire logic        e_sop,
  input  wire logic        e_eop,
  // customer side frames out
  output logic             c_valid,
  input  wire logic        c_ready,
  output logic      [31:0] c_data,
  output logic             c_sop,
  output logic             c_eop
);

  // whole block state, one register
  pwe_pkg::pwe_state_s s_q;
  pwe_pkg::pwe_state_s s_d;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // feature enables
  logic        cw_en;
  logic        fl_en;

  // flow hash path
  logic [47:0] mac_mix;
  logic [19:0] hash_raw;
  logic [19:0] hash_val;

  // output slot space
  logic        m_free;
  logic        c_free;

  // register read path
  logic [31:0] rd_mux;

  // either profile or peer setting turns a feature on
  assign cw_en = s_q.ctrl[`PWE_CW_BIT] | s_q.peer[`PWE_CW_BIT];
  assign fl_en = s_q.ctrl[`PWE_FL_BIT] | s_q.peer[`PWE_FL_BIT];

  // local fold of mac keys, salted by pw label, never signalled
  assign mac_mix  = i_dmac ^ {i_smac[23:0], i_smac[47:24]};
  assign hash_raw = mac_mix[19:0] ^ mac_mix[39:20] ^ {12'h000, mac_mix[47:40]}
                    ^ s_q.pw_lbl;
  // push hash out of the reserved range
  // forcing the top bit keeps one flow on one label
  assign hash_val = (hash_raw <= `PWE_RSV_LBL_MAX) ? (hash_raw | 20'h8_0000)
                                                   : hash_raw;

  // output slot free when empty or draining
  assign m_free = !s_q.m_valid || m_ready;
  assign c_free = !s_q.c_valid || c_ready;

  // read data mux, registered at address phase
  // hazard: a read right behind a write to the same word sees the old value
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      `PWE_CTRL_OFS:   rd_mux = {29'h0000_0000, s_q.ctrl};
      `PWE_PEER_OFS:   rd_mux = {30'h0000_0000, s_q.peer};
      `PWE_PWLBL_OFS:  rd_mux = {12'h000, s_q.pw_lbl};
      `PWE_TUNLBL_OFS: rd_mux = {12'h000, s_q.tun_lbl};
      `PWE_CAP_OFS:    rd_mux = {30'h0000_0000, `PWE_CAP_VAL};
      `PWE_STAT_OFS:   rd_mux = {s_q.drops, s_q.seq};
      `PWE_DEPTH_OFS:  rd_mux = {28'h000_0000, s_q.depth};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    s_d = s_q;

    // bus: zero wait, always okay
    // address phase captured here, write lands at end of data phase
    s_d.hreadyout = 1'b1;
    s_d.hresp     = 1'b0;
    s_d.a_valid   = hsel && htrans[1] && hready;
    s_d.a_write   = hwrite;
    s_d.a_addr    = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite)
    begin
      s_d.hrdata = rd_mux;
    end
    if (s_q.a_valid && s_q.a_write)
    begin
      unique case (s_q.a_addr)
        `PWE_CTRL_OFS:   s_d.ctrl    = hwdata[2:0];
        `PWE_PEER_OFS:   s_d.peer    = hwdata[1:0];
        `PWE_PWLBL_OFS:  s_d.pw_lbl  = hwdata[19:0];
        `PWE_TUNLBL_OFS: s_d.tun_lbl = hwdata[19:0];
        `PWE_DEPTH_OFS:  s_d.depth   = hwdata[3:0];
        default:         ;
      endcase
    end

    // ingress output stage drains
    if (s_q.m_valid && m_ready)
    begin
      s_d.m_valid = 1'b0;
    end

    // ingress header build and payload pass
    // stack entry: label[31:12] exp[11:9] s[8] ttl[7:0]
    // header order: tunnel, pw, flow label, control word
    // a header word leaves only when the output slot is free
    unique case (s_q.ist)
      pwe_pkg::I_IDLE:
      begin
        // latch features and flow label at start of frame
        if (i_valid && i_sop)
        begin
          s_d.cw_act = cw_en;
          s_d.fl_act = fl_en && (s_q.depth <= `PWE_MAX_LB_LBLS);
          s_d.flow   = hash_val;
          s_d.ist    = pwe_pkg::I_TUN;
        end
      end
      pwe_pkg::I_TUN:
      begin
        // tunnel entry on top, never bottom of stack
        if (m_free)
        begin
          s_d.m_valid = 1'b1;
          s_d.m_sop   = 1'b1;
          s_d.m_eop   = 1'b0;
          s_d.m_data  = {s_q.tun_lbl, `PWE_EXP_VAL, 1'b0, `PWE_TUN_TTL};
          s_d.ist     = pwe_pkg::I_PW;
        end
      end
      pwe_pkg::I_PW:
      begin
        if (m_free)
        begin
          s_d.m_valid = 1'b1;
          s_d.m_sop   = 1'b0;
          // bottom of stack only when no flow label follows
          s_d.m_data  = {s_q.pw_lbl, `PWE_EXP_VAL, !s_q.fl_act, `PWE_PW_TTL};
          s_d.ist     = s_q.fl_act ? pwe_pkg::I_FL
                      : (s_q.cw_act ? pwe_pkg::I_CW : pwe_pkg::I_PAY);
        end
      end
      pwe_pkg::I_FL:
      begin
        // flow entry closes the label stack
        if (m_free)
        begin
          s_d.m_valid = 1'b1;
          s_d.m_sop   = 1'b0;
          s_d.m_data  = {s_q.flow, `PWE_EXP_VAL, 1'b1, `PWE_FL_TTL};
          s_d.ist     = s_q.cw_act ? pwe_pkg::I_CW : pwe_pkg::I_PAY;
        end
      end
      pwe_pkg::I_CW:
      begin
        if (m_free)
        begin
          s_d.m_valid = 1'b1;
          s_d.m_sop   = 1'b0;
          // zero nibble, reserved zeros, sequence or zero
          s_d.m_data  = {`PWE_CW_NIBBLE, `PWE_CW_RSV,
                         s_q.ctrl[`PWE_SEQ_BIT] ? s_q.seq : 16'h0000};
          if (s_q.ctrl[`PWE_SEQ_BIT])
          begin
            // skip zero on wrap, it means no checking
            s_d.seq = (s_q.seq == 16'hFFFF) ? 16'h0001 : s_q.seq + 16'h0001;
          end
          s_d.ist = pwe_pkg::I_PAY;
        end
      end
      pwe_pkg::I_PAY:
      begin
        // payload passes one word per empty slot
        if (i_valid && s_q.i_ready)
        begin
          s_d.m_valid = 1'b1;
          s_d.m_sop   = 1'b0;
          s_d.m_eop   = i_eop;
          s_d.m_data  = i_data;
          if (i_eop)
          begin
            s_d.ist = pwe_pkg::I_IDLE;
          end
        end
      end
      default: s_d.ist = pwe_pkg::I_IDLE;
    endcase
    // payload accepted only into an empty output slot
    s_d.i_ready = (s_d.ist == pwe_pkg::I_PAY) && !s_d.m_valid;

    // egress output stage drains
    // a taken word empties the slot; a payload word is only taken into an empty one
    if (s_q.c_valid && c_ready)
    begin
      s_d.c_valid = 1'b0;
    end

    // egress label and control word strip
    // first word must carry our pw label
    // a flow entry follows when flow label is on and the pw entry has s=0
    // foreign packets are counted and swallowed
    if (e_valid && s_q.e_ready)
    begin
      unique case (s_q.est)
        pwe_pkg::E_TOP:
        begin
          // top entry must match our pw label
          s_d.first = 1'b1;
          if (e_sop && e_data[31:12] == s_q.pw_lbl)
          begin
            if (e_eop)
            begin
              s_d.est = pwe_pkg::E_TOP;
            end
            else if (fl_en && !e_data[8])
            begin
              s_d.est = pwe_pkg::E_FL;
            end
            else
            begin
              s_d.est = cw_en ? pwe_pkg::E_CW : pwe_pkg::E_PAY;
            end
          end
          else
          begin
            s_d.drops = s_q.drops + 16'h0001;
            s_d.est   = e_eop ? pwe_pkg::E_TOP : pwe_pkg::E_DROP;
          end
        end
        pwe_pkg::E_FL:
        begin
          // flow label dropped unread
          s_d.est = e_eop ? pwe_pkg::E_TOP
                  : (cw_en ? pwe_pkg::E_CW : pwe_pkg::E_PAY);
        end
        pwe_pkg::E_CW:
        begin
          // control word discarded without looking inside
          s_d.est = e_eop ? pwe_pkg::E_TOP : pwe_pkg::E_PAY;
        end
        pwe_pkg::E_PAY:
        begin
          // payload handed to customer side
          s_d.c_valid = 1'b1;
          s_d.c_data  = e_data;
          s_d.c_sop   = s_q.first;
          s_d.c_eop   = e_eop;
          s_d.first   = 1'b0;
          if (e_eop)
          begin
            s_d.est = pwe_pkg::E_TOP;
          end
        end
        pwe_pkg::E_DROP:
        begin
          // swallow rest of a foreign packet
          if (e_eop)
          begin
            s_d.est = pwe_pkg::E_TOP;
          end
        end
        default: s_d.est = pwe_pkg::E_TOP;
      endcase
    end
    // stall egress only while a payload word waits
    s_d.e_ready = (s_d.est != pwe_pkg::E_PAY) || !s_d.c_valid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // whole state struct, reset to idle values
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q           <= '0;
      s_q.hreadyout <= 1'b1;
      s_q.ctrl      <= `PWE_CTRL_RST;
      s_q.peer      <= `PWE_PEER_RST;
      s_q.pw_lbl    <= `PWE_LBL_RST;
      s_q.tun_lbl   <= `PWE_LBL_RST;
      s_q.depth     <= `PWE_DEPTH_RST;
      s_q.ist       <= pwe_pkg::I_IDLE;
      s_q.est       <= pwe_pkg::E_TOP;
      // sequence restarts at one, zero means unchecked
      s_q.seq       <= `PWE_SEQ_RST;
      s_q.e_ready   <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register

  // bus
  assign hrdata    = s_q.hrdata;
  assign hreadyout = s_q.hreadyout;
  assign hresp     = s_q.hresp;

  // ingress
  assign i_ready   = s_q.i_ready;
  assign m_valid   = s_q.m_valid;
  assign m_data    = s_q.m_data;
  assign m_sop     = s_q.m_sop;
  assign m_eop     = s_q.m_eop;

  // egress
  assign e_ready   = s_q.e_ready;
  assign c_valid   = s_q.c_valid;
  assign c_data    = s_q.c_data;
  assign c_sop     = s_q.c_sop;
  assign c_eop     = s_q.c_eop;

endmodule : pwe_core

//--- tb/pwe_core_sva.sv
`timescale 1ns/1ns
// protocol checker on the core ports
module pwe_core_sva (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        m_valid,
  input wire logic        m_ready,
  input wire logic [31:0] m_data,
  input wire logic        m_sop,
  input wire logic        c_valid,
  input wire logic        c_ready,
  input wire logic [31:0] c_data,
  input wire logic        c_eop
);
  logic [2:0] idx_q;
  logic       s_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // word position in packet, pw entry stack bit
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      idx_q <= 3'h0;
      s_q   <= 1'b0;
    end
    else if (m_valid && m_ready)
    begin
      idx_q <= m_sop ? 3'h1 : idx_q + {2'h0, idx_q != 3'h7};
      if (idx_q == 3'h1 && !m_sop)
        s_q <= m_data[8];
    end
  // bus always ready and okay
  property p_hrdy; hreadyout; endproperty
  a_hrdy: assert property (p_hrdy) else $error("bus wait");
  property p_hresp; !hresp; endproperty
  a_hresp: assert property (p_hresp) else $error("bus error");
  // outputs hold while stalled
  property p_mhold; m_valid && !m_ready |=> m_valid && $stable(m_data); endproperty
  a_mhold: assert property (p_mhold) else $error("mpls word dropped");
  property p_chold; c_valid && !c_ready |=> c_valid && $stable(c_data); endproperty
  a_chold: assert property (p_chold) else $error("frame word dropped");
  // label stack entries, and no valid output right after reset
  property p_tun; m_valid && m_sop |-> m_data[8:0] == 9'h0FF; endproperty
  a_tun: assert property (p_tun) else $error("tunnel entry");
  property p_pw; m_valid && !m_sop && idx_q == 3'h1 |-> m_data[7:0] == 8'hFF; endproperty
  a_pw: assert property (p_pw) else $error("pw entry");
  property p_fl; m_valid && !m_sop && idx_q == 3'h2 && !s_q |-> m_data[8:0] == 9'h100; endproperty
  a_fl: assert property (p_fl) else $error("flow entry bits");
  property p_flr; m_valid && !m_sop && idx_q == 3'h2 && !s_q |-> m_data[31:12] > 20'h0_000F; endproperty
  a_flr: assert property (p_flr) else $error("flow label reserved");
  property p_rst; $rose(rst_n) |-> !m_valid && !c_valid; endproperty
  a_rst: assert property (p_rst) else $error("valid after reset");
  // main scenarios
  c_fl: cover property (m_valid && m_ready && idx_q == 3'h2 && !s_q);
  c_end: cover property (c_valid && c_ready && c_eop);
  c_mst: cover property (m_valid && !m_ready);
endmodule : pwe_core_sva
bind pwe_core pwe_core_sva pwe_core_sva_i (.ref_clk(ref_clk), .rst_n(rst_n), .hreadyout(hreadyout),
  .hresp(hresp), .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data), .m_sop(m_sop),
  .c_valid(c_valid), .c_ready(c_ready), .c_data(c_data), .c_eop(c_eop));

//--- tb/pwe_mpls_peer.sv
`timescale 1ns/1ns
// far side: transit sink and remote edge source
module pwe_mpls_peer (
  input  wire logic        ref_clk,
  input  wire logic        m_valid,
  output logic             m_ready,
  input  wire logic [31:0] m_data,
  input  wire logic        m_sop,
  input  wire logic        m_eop,
  output logic             e_valid,
  input  wire logic        e_ready,
  output logic [31:0]      e_data,
  output logic             e_sop,
  output logic             e_eop
);
  logic [31:0] rx[$];
  logic [1:0]  rf[$];
  int          seed = 68301;
  initial
  begin
    m_ready = 1'b0;
    e_valid = 1'b0;
    e_data  = 32'h0000_0000;
    e_sop   = 1'b0;
    e_eop   = 1'b0;
  end
  // in-order sink, no sequence check, random stalls
  always @(posedge ref_clk)
  begin
    if (m_valid && m_ready)
    begin
      rx.push_back(m_data);
      rf.push_back({m_sop, m_eop});
    end
    m_ready <= ($random(seed) & 3) != 0;
  end
  // remote edge sends one labelled packet
  task automatic send(input logic [31:0] w[$], output bit late);
    int k;
    late = 1'b0;
    foreach (w[i])
    begin
      e_valid <= 1'b1;
      e_data  <= w[i];
      e_sop   <= i == 0;
      e_eop   <= i == w.size() - 1;
      k = 0;
      do @(posedge ref_clk); while (e_ready !== 1'b1 && ++k < 200);
      if (k >= 200)
        late = 1'b1;
    end
    e_valid <= 1'b0;
    e_data  <= ~w[w.size() - 1];
  endtask : send
endmodule : pwe_mpls_peer

//--- tb/tb.sv
`timescale 1ns/1ns
`include "pwe_cfg.svh"
module tb;
  logic        ref_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic        i_valid, i_ready, i_sop, i_eop, m_valid, m_ready, m_sop, m_eop;
  logic        e_valid, e_ready, e_sop, e_eop, c_valid, c_ready, c_sop, c_eop;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, i_data, m_data, e_data, c_data, rd;
  logic [47:0] i_dmac, i_smac;
  logic [19:0] pw, tun, fa, fb;
  logic [31:0] cq[$], pl[$];
  logic [1:0]  cf[$];
  int          seed = 68301;
  int          fail_count = 0;
  int          total_checks = 0;
  assign hready = hreadyout;
  pwe_core pwe_core_i (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .i_valid(i_valid), .i_ready(i_ready), .i_data(i_data), .i_sop(i_sop), .i_eop(i_eop),
    .i_dmac(i_dmac), .i_smac(i_smac), .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data), .m_sop(m_sop),
    .m_eop(m_eop), .e_valid(e_valid), .e_ready(e_ready), .e_data(e_data), .e_sop(e_sop), .e_eop(e_eop),
    .c_valid(c_valid), .c_ready(c_ready), .c_data(c_data), .c_sop(c_sop), .c_eop(c_eop));
  pwe_mpls_peer peer (.ref_clk(ref_clk), .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data),
    .m_sop(m_sop), .m_eop(m_eop), .e_valid(e_valid), .e_ready(e_ready), .e_data(e_data), .e_sop(e_sop),
    .e_eop(e_eop));
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // stripped frame collector with random stalls
  always @(posedge ref_clk)
  begin
    if (c_valid && c_ready)
    begin
      cq.push_back(c_data);
      cf.push_back({c_sop, c_eop});
    end
    c_ready <= ($random(seed) & 3) != 0;
  end
  function automatic logic [31:0] lse(input logic [19:0] l, input logic s, input logic [7:0] t);
    return {l, 3'h0, s, t};
  endfunction : lse
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic tmo;
    fail_count++;
    $display("[ERR] %0t wait ran out", $time);
    wrap_up();
  endtask : tmo
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : ck
  // one ahb-lite single word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge ref_clk); while (hready !== 1'b1 && ++n < 64);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1 && ++n < 64);
    rd = hrdata;
    if (n >= 64)
      tmo();
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    ck(rd, e);
  endtask : rdc
  // customer frame of n random words
  task automatic frame(input int n);
    int k;
    pl = {};
    for (int i = 0; i < n; i++)
    begin
      pl.push_back($random(seed));
      i_valid <= 1'b1;
      i_data  <= pl[i];
      i_sop   <= i == 0;
      i_eop   <= i == n - 1;
      k = 0;
      do @(posedge ref_clk); while (i_ready !== 1'b1 && ++k < 200);
      if (k >= 200)
        tmo();
    end
    i_valid <= 1'b0;
  endtask : frame
  // compare one encapsulated packet, return flow label
  task automatic pkt(input logic fl, input logic cw, input logic [15:0] sq, output logic [19:0] fv);
    int          k;
    int          n;
    logic [31:0] w;
    k = 0;
    n = 2 + fl + cw + pl.size();
    fv = 20'h0_0000;
    while (peer.rx.size() < n)
    begin
      if (++k > 400)
        tmo();
      @(posedge ref_clk);
    end
    for (int j = 0; j < n; j++)
      ck({30'h0000_0000, peer.rf.pop_front()}, {30'h0000_0000, j == 0, j == n - 1});
    ck(peer.rx.pop_front(), lse(tun, 1'b0, 8'hFF));
    ck(peer.rx.pop_front(), lse(pw, !fl, 8'hFF));
    if (fl)
    begin
      w = peer.rx.pop_front();
      fv = w[31:12];
      ck({20'h0_0000, w[11:0]}, 32'h0000_0100);
      ck({31'h0000_0000, fv > 20'h0_000F}, 32'h0000_0001);
    end
    if (cw)
      ck(peer.rx.pop_front(), {16'h0000, sq});
    foreach (pl[i])
      ck(peer.rx.pop_front(), pl[i]);
  endtask : pkt
  initial
  begin
    int k;
    bit lt;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    i_valid = 1'b0;
    i_data = 32'h0000_0000;
    i_sop = 1'b0;
    i_eop = 1'b0;
    c_ready = 1'b0;
    i_dmac = {16'($random(seed)), 32'($random(seed))};
    i_smac = {16'($random(seed)), 32'($random(seed))};
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    bus(1'b1, `PWE_CAP_OFS, 32'h0000_0000);
    rdc(`PWE_CAP_OFS, 32'h0000_0003);
    rdc(8'h40, 32'h0000_0000);
    pw = 20'($random(seed));
    tun = 20'($random(seed));
    bus(1'b1, `PWE_PWLBL_OFS, {12'h000, pw});
    bus(1'b1, `PWE_TUNLBL_OFS, {12'h000, tun});
    bus(1'b1, `PWE_CTRL_OFS, 32'h0000_0007);
    frame(3);
    pkt(1'b1, 1'b1, 16'h0001, fa);
    frame(1);
    pkt(1'b1, 1'b1, 16'h0002, fb);
    ck({12'h000, fb}, {12'h000, fa});
    bus(1'b1, `PWE_CTRL_OFS, 32'h0000_0000);
    bus(1'b1, `PWE_PEER_OFS, 32'h0000_0003);
    frame(2);
    pkt(1'b1, 1'b1, 16'h0000, fa);
    bus(1'b1, `PWE_DEPTH_OFS, 32'h0000_0004);
    bus(1'b1, `PWE_PEER_OFS, 32'h0000_0003);
    frame(2);
    pkt(1'b0, 1'b1, 16'h0000, fa);
    bus(1'b1, `PWE_DEPTH_OFS, 32'h0000_0003);
    bus(1'b1, `PWE_PEER_OFS, 32'h0000_0002);
    frame(1);
    pkt(1'b1, 1'b0, 16'h0000, fa);
    // corner: zero keys and a small pw label put the raw hash in 0..15
    i_dmac <= 48'h0000_0000_0000;
    i_smac <= 48'h0000_0000_0000;
    pw = 20'h0_0007;
    bus(1'b1, `PWE_PWLBL_OFS, {12'h000, pw});
    frame(1);
    pkt(1'b1, 1'b0, 16'h0000, fa);
    bus(1'b1, `PWE_PEER_OFS, 32'h0000_0003);
    pl = {32'($random(seed)), 32'($random(seed))};
    peer.send({lse(pw, 1'b0, 8'hFF), lse(20'h0_0ABC, 1'b1, 8'h00), 32'h0000_0005, pl[0], pl[1]}, lt);
    if (lt)
      tmo();
    k = 0;
    while (cq.size() < 2 && ++k < 200)
      @(posedge ref_clk);
    if (cq.size() < 2)
      tmo();
    ck(cq.pop_front(), pl[0]);
    ck({30'h0000_0000, cf.pop_front()}, 32'h0000_0002);
    ck(cq.pop_front(), pl[1]);
    ck({30'h0000_0000, cf.pop_front()}, 32'h0000_0001);
    peer.send({lse(pw ^ 20'h0_0001, 1'b0, 8'hFF), pl[0]}, lt);
    if (lt)
      tmo();
    repeat (20) @(posedge ref_clk);
    ck(32'(cq.size()), 32'h0000_0000);
    bus(1'b0, `PWE_STAT_OFS, 32'h0000_0000);
    ck({16'h0000, rd[31:16]}, 32'h0000_0001);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdc(`PWE_STAT_OFS, 32'h0000_0001);
    wrap_up();
  end
endmodule : tb
